// ### rtl/eeprom_cmd_pkg.sv
// package for the serial eeprom command block
// shared by the design and the bench; no assumptions beyond a 20 MHz clock
package eeprom_cmd_pkg;
  localparam int WORD_W     = 16;
  localparam int ADDR_W     = 10;
  localparam int OP_W       = 2;
  localparam int FRAME_W    = OP_W + ADDR_W;
  localparam int CLK_HZ     = 20_000_000;
  localparam int PROG_MAX_US = 10_000;
  localparam int PROG_CYCLES_MAX = (PROG_MAX_US * (CLK_HZ / 1_000_000));
  localparam int PROG_CYCLES_DEF = 80_000;
  localparam logic [OP_W-1:0] OP_READ  = 2'h2;
  localparam logic [OP_W-1:0] OP_WRITE = 2'h1;
  localparam logic [OP_W-1:0] OP_ERASE = 2'h3;
  localparam logic [OP_W-1:0] OP_MISC  = 2'h0;
  localparam logic [1:0] MISC_ENABLE   = 2'h3;
  localparam logic [1:0] MISC_DISABLE  = 2'h0;
  localparam logic [WORD_W-1:0] ERASED_WORD = 16'hFFFF;

  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_PROG} phase_t;

  typedef struct packed {
    logic serial_clock;
    logic serial_data_in;
    logic chip_select;
  } link_in_t;

  typedef struct packed {
    logic data_out;
    logic data_out_en;
  } link_out_t;

  typedef struct packed {
    logic              req;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } prog_req_t;
endpackage

// ### rtl/eeprom_cmd.sv
// command logic of a 16-bit word serial eeprom: start bit, erase, enable/disable,
// self-timed programming and busy/ready polling on data-out.
// assumes link pins already synchronous to clk; storage array is held here.
// Functional notes
// - erase targets one addressed 16-bit word
// - erase frame is start, opcode, address only
// - chip select fall starts erase to ones
// - enable command permits write and erase
// - disable command rejects write and erase
// - power-up starts write protected
// - start bit needs data-in high on rise
// - programming starts on select fall after frame
// - busy shows data-out low when selected
// - ready shows data-out high after completion
// - data-out driven only during or after a programming cycle
// - start bit returns data-out to high impedance, unless it comes in the same cycle as the select rise after completion
// - clock and data-in ignored throughout programming cycle; chip select still gates data-out
// - link ignored while chip select low
// - low data-in clocks are dummy clocks
`timescale 1ns/1ps
module eeprom_cmd
  import eeprom_cmd_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYCLES_DEF
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       sys_rst,
  // serial link from host
  input  wire eeprom_cmd_pkg::link_in_t   link_in,
  // data-out pin, enable high while driven
  output logic                            data_out,
  output logic                            data_out_en,
  // status
  output logic                            program_enabled,
  output logic                            busy
);
  import eeprom_cmd_pkg::*;

  // counter wide enough for the whole programming time
  localparam int CNT_W = $clog2(PROG_CYCLES + 1);

  // bit counters hold up to one frame or one word
  localparam int BIT_W = 5;

  localparam logic [BIT_W-1:0] FRAME_BITS = BIT_W'(FRAME_W);
  localparam logic [BIT_W-1:0] WORD_BITS  = BIT_W'(WORD_W);
  localparam logic [BIT_W-1:0] BIT_ONE    = BIT_W'(1);
  localparam logic [CNT_W-1:0] CNT_LOAD   = CNT_W'(PROG_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST   = CNT_W'(1);

  typedef struct packed {
    phase_t              phase;
    logic                sk_prev;
    logic                cs_prev;
    logic                wr_en;
    logic [BIT_W-1:0]    nbits;
    logic [FRAME_W-1:0]  frame;
    logic [WORD_W-1:0]   data;
    logic [BIT_W-1:0]    ndata;
    logic [CNT_W-1:0]    cnt;
    logic                done;
    logic                drive;
    logic                dout;
    prog_req_t           prog;
  } state_t;

  state_t            st_reg;
  state_t            st_next;
  link_out_t         pin_next;
  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];

  // opcode field sits right behind the start bit
  function automatic logic [OP_W-1:0] op_of(input logic [FRAME_W-1:0] f);
    op_of = f[FRAME_W-1 -: OP_W];
  endfunction

  function automatic logic [ADDR_W-1:0] addr_of(input logic [FRAME_W-1:0] f);
    addr_of = f[ADDR_W-1:0];
  endfunction

  // the two top address bits tell enable and disable apart
  function automatic logic [1:0] misc_of(input logic [FRAME_W-1:0] f);
    misc_of = f[ADDR_W-1 -: 2];
  endfunction

  function automatic logic is_prog_op(input logic [OP_W-1:0] op);
    is_prog_op = (op == OP_WRITE) || (op == OP_ERASE);
  endfunction

  function automatic logic is_enable_frame(input logic [FRAME_W-1:0] f);
    is_enable_frame = (op_of(f) == OP_MISC) && (misc_of(f) == MISC_ENABLE);
  endfunction

  function automatic logic is_disable_frame(input logic [FRAME_W-1:0] f);
    is_disable_frame = (op_of(f) == OP_MISC) && (misc_of(f) == MISC_DISABLE);
  endfunction

  function automatic logic [FRAME_W-1:0] shift_frame(
    input logic [FRAME_W-1:0] f,
    input logic               b
  );
    shift_frame = {f[FRAME_W-2:0], b};
  endfunction

  function automatic logic [WORD_W-1:0] shift_word(
    input logic [WORD_W-1:0] w,
    input logic              b
  );
    shift_word = {w[WORD_W-2:0], b};
  endfunction

  // erase needs no data bits; a write short of a full word never programs
  function automatic logic prog_ok(
    input logic [FRAME_W-1:0] f,
    input logic [BIT_W-1:0]   nd,
    input logic               en
  );
    logic data_ok;
    data_ok = (op_of(f) == OP_ERASE) || (nd == WORD_BITS);
    prog_ok = is_prog_op(op_of(f)) && en && data_ok;
  endfunction

  logic              sk_rise;
  logic              cs_fall;
  logic              cs_rise;
  logic              start_bit;
  logic              frame_full;
  logic              word_full;
  logic              cnt_last;
  logic [WORD_W-1:0] prog_word;

  assign sk_rise    = link_in.serial_clock && !st_reg.sk_prev;
  assign cs_fall    = !link_in.chip_select && st_reg.cs_prev;
  assign cs_rise    = link_in.chip_select && !st_reg.cs_prev;
  assign start_bit  = link_in.chip_select && sk_rise && link_in.serial_data_in;
  assign frame_full = (st_reg.nbits == FRAME_BITS);
  assign word_full  = (st_reg.ndata == WORD_BITS);
  assign cnt_last   = (st_reg.cnt == CNT_LAST);

  // word to store, chosen bit by bit
  for (genvar b = 0; b < WORD_W; b++) begin : g_word
    assign prog_word[b] = st_reg.prog.erase ? ERASED_WORD[b] : st_reg.prog.data[b];
  end

  always_comb begin
    st_next          = st_reg;
    st_next.sk_prev  = link_in.serial_clock;
    st_next.cs_prev  = link_in.chip_select;
    st_next.prog.req = 1'b0;
    case (st_reg.phase)
      ST_IDLE: begin
        if (start_bit) begin
          st_next.phase = ST_SHIFT;
          st_next.nbits = '0;
          st_next.ndata = '0;
          st_next.drive = 1'b0;
        end
        if (!link_in.chip_select) begin
          st_next.drive = 1'b0;
        end else if (st_reg.done && cs_rise) begin
          st_next.drive = 1'b1;
          st_next.dout  = 1'b1;
        end
      end
      ST_SHIFT: begin
        if (cs_fall) begin
          st_next.phase = ST_IDLE;
          st_next.done  = 1'b0;
          if (frame_full && is_enable_frame(st_reg.frame)) begin
            st_next.wr_en = 1'b1;
          end
          if (frame_full && is_disable_frame(st_reg.frame)) begin
            st_next.wr_en = 1'b0;
          end
          if (frame_full && prog_ok(st_reg.frame, st_reg.ndata, st_reg.wr_en)) begin
            st_next.phase      = ST_PROG;
            st_next.cnt        = CNT_LOAD;
            st_next.prog.req   = 1'b1;
            st_next.prog.erase = (op_of(st_reg.frame) == OP_ERASE);
            st_next.prog.addr  = addr_of(st_reg.frame);
            st_next.prog.data  = st_reg.data;
          end
        end else if (link_in.chip_select && sk_rise) begin
          if (!frame_full) begin
            st_next.frame = shift_frame(st_reg.frame, link_in.serial_data_in);
            st_next.nbits = st_reg.nbits + BIT_ONE;
          end else begin
            // overflow keeps only the last word shifted in
            st_next.data = shift_word(st_reg.data, link_in.serial_data_in);
            if (!word_full) begin
              st_next.ndata = st_reg.ndata + BIT_ONE;
            end
          end
        end
      end
      ST_PROG: begin
        // serial clock and data-in are not looked at here
        st_next.cnt   = st_reg.cnt - CNT_LAST;
        st_next.drive = link_in.chip_select;
        st_next.dout  = 1'b0;
        if (cnt_last) begin
          st_next.phase = ST_IDLE;
          st_next.done  = 1'b1;
          st_next.dout  = 1'b1;
        end
      end
      default: begin
        st_next.phase = ST_IDLE;
      end
    endcase
  end

  // pin values travel together into the output flops
  always_comb begin
    pin_next             = '0;
    pin_next.data_out    = st_next.dout;
    pin_next.data_out_en = st_next.drive;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_reg       <= '0;
      st_reg.phase <= ST_IDLE;
      st_reg.wr_en <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // storage updated once per accepted programming request
  always_ff @(posedge clk) begin
    if (st_reg.prog.req) begin
      mem[st_reg.prog.addr] <= prog_word;
    end
  end

  // outputs straight from flops, so the pin never glitches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      data_out        <= 1'b0;
      data_out_en     <= 1'b0;
      program_enabled <= 1'b0;
      busy            <= 1'b0;
    end else begin
      data_out        <= pin_next.data_out;
      data_out_en     <= pin_next.data_out_en;
      program_enabled <= st_next.wr_en;
      busy            <= (st_next.phase == ST_PROG);
    end
  end
endmodule // eeprom_cmd

// ### bench/eeprom_cmd_chk.sv
// port checker for eeprom_cmd
// sees only the top ports; bound below
`timescale 1ns/1ps
module eeprom_cmd_chk
  import eeprom_cmd_pkg::*;
#(parameter int PROG_CYCLES = 20) (
  // block ports
  input wire logic                     clk,
  input wire logic                     sys_rst,
  input wire eeprom_cmd_pkg::link_in_t link_in,
  input wire logic                     data_out,
  input wire logic                     data_out_en,
  input wire logic                     program_enabled,
  input wire logic                     busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire  cs = link_in.chip_select;
  int   n_reg;
  logic ran_reg;
  // weak but cheap: any earlier programming cycle permits a drive
  always_ff @(posedge clk) begin
    n_reg   <= (busy && !sys_rst) ? n_reg + 1 : 0;
    ran_reg <= !sys_rst && (ran_reg || busy);
  end
  chk_busy_len: assert property ($fell(busy) |-> n_reg == PROG_CYCLES)
    else $error("busy length");
  chk_busy_low: assert property (busy && $past(busy) && cs && $past(cs)
    |-> data_out_en && !data_out) else $error("busy level");
  chk_prot_idle: assert property (!program_enabled && !busy |=> !busy)
    else $error("protected start");
  chk_power_prot: assert property ($past(sys_rst) |-> !program_enabled && !data_out_en)
    else $error("reset state");
  chk_busy_cause: assert property ($rose(busy) |-> !cs && $past(program_enabled))
    else $error("busy cause");
  chk_ready_high: assert property ($fell(busy) && cs |-> ##[0:1] data_out && data_out_en)
    else $error("ready level");
  chk_drive_cause: assert property (data_out_en |-> ran_reg) else $error("early drive");
  chk_start_hiz: assert property (data_out_en && !busy && cs && link_in.serial_data_in
    && $rose(link_in.serial_clock) |-> ##[1:3] !data_out_en) else $error("start drive");
  chk_busy_deaf: assert property (busy |=> $stable(program_enabled)) else $error("deaf");
  cover property ($rose(busy));
  cover property ($rose(program_enabled));
  cover property ($fell(data_out_en));
endmodule // eeprom_cmd_chk
bind eeprom_cmd eeprom_cmd_chk #(.PROG_CYCLES(PROG_CYCLES)) chk_i (.clk, .sys_rst,
  .link_in, .data_out, .data_out_en, .program_enabled, .busy);

// ### bench/eeprom_host.sv
// host model driving the serial link
// assumes the bench clock; pins change only at its rising edge
`timescale 1ns/1ps
module eeprom_host
  import eeprom_cmd_pkg::*;
(
  // bench clock and link pins
  input  wire logic                 clk,
  output eeprom_cmd_pkg::link_in_t  lk
);
  initial lk = '0;
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sel(logic v);
    lk.chip_select <= v;
    tick(2);
  endtask
  // serial clock idles low between frames
  task automatic clk_bit(logic b);
    lk.serial_data_in <= b;
    tick(2);
    lk.serial_clock <= 1'b1;
    tick(2);
    lk.serial_clock <= 1'b0;
  endtask
  task automatic send(logic [FRAME_W-1:0] f, int dummies);
    sel(1'b1);
    repeat (dummies) clk_bit(1'b0);
    clk_bit(1'b1);
    for (int i = FRAME_W - 1; i >= 0; i--) clk_bit(f[i]);
    tick(1);
    lk.serial_data_in <= 1'b0;
    lk.chip_select <= 1'b0;
    tick(3);
  endtask
endmodule // eeprom_host

// ### bench/serial_eeprom_erase_protect_test.sv
// self-checking bench for eeprom_cmd
// assumes eeprom_host on the link and the bound checker
`timescale 1ns/1ps
module serial_eeprom_erase_protect_test;
  import eeprom_cmd_pkg::*;
  localparam int PC = 200;
  logic     clk, sys_rst, data_out, data_out_en, program_enabled, busy, en;
  link_in_t lk;
  int       failures, samples_checked, seed, n;
  eeprom_host host (.clk, .lk);
  eeprom_cmd #(.PROG_CYCLES(PC)) uut (.clk, .sys_rst, .link_in(lk), .data_out,
    .data_out_en, .program_enabled, .busy);
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic check(logic seen, logic exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic mode(logic on, int dummies);
    host.send({OP_MISC, on ? MISC_ENABLE : MISC_DISABLE, (ADDR_W-2)'($random(seed))}, dummies);
    check(program_enabled, on);
  endtask
  // frame sent while busy must be ignored, so protection stays off
  task automatic erase_try(logic on);
    host.send({OP_ERASE, ADDR_W'($random(seed))}, 0);
    check(busy, on);
    if (on) host.send({OP_MISC, MISC_DISABLE, (ADDR_W-2)'($random(seed))}, 1);
    check(program_enabled, on);
    host.sel(1'b1);
    check(data_out_en, on);
    check(data_out_en & data_out, 1'b0);
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      @(posedge clk);
      n++;
    end
    if (n == 1000) failures++;
    if (n == 1000) report_and_stop();
    if (on) begin
      host.tick(2);
      check(data_out, 1'b1);
      host.clk_bit(1'b1);
      host.tick(2);
      check(data_out_en, 1'b0);
    end
    host.sel(1'b0);
    $display("erase test done, enabled %0d", on);
  endtask
  initial begin
    #4_000_000;
    failures++;
    report_and_stop();
  end
  initial begin
    seed = 32768;
    failures = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    host.tick(2);
    check(program_enabled, 1'b0);
    erase_try(1'b0);
    mode(1'b1, 3);
    erase_try(1'b1);
    for (int i = 0; i < 6; i++) begin
      en = 1'($random(seed));
      mode(en, i % 3);
      erase_try(en);
    end
    mode(1'b0, 0);
    report_and_stop();
  end
endmodule // serial_eeprom_erase_protect_test
